//--- rtl/lca_pkg.sv
package lca_pkg;
    // number of cells and grouping of routed side bits
    localparam int CELL_COUNT = 8;
    localparam int GROUP_SIZE = 4;
    // decoded address width; higher address bits must be zero
    localparam int ADDR_W = 8;
    // register pages, each holding one word per cell
    localparam int PAGE_LSB = 5;
    localparam int INDEX_LSB = 2;
    localparam int INDEX_W = 3;
    localparam logic [2:0] CTL_PAGE = 3'h0;
    localparam logic [2:0] SEL_PAGE = 3'h1;
    localparam logic [7:0] ENABLE_OFFSET = 8'h40;
    localparam logic [7:0] STATUS_OFFSET = 8'h44;
    // control register fields
    localparam int TRUTH_LSB = 0;
    localparam int TRUTH_W = 8;
    localparam int FUNC_LSB = 8;
    localparam int FUNC_W = 2;
    localparam logic [31:0] CTL_MASK = 32'h0000_03ff;
    localparam logic [31:0] CTL_RESET = 32'h0000_0000;
    // input select register fields
    localparam int SRC_A_LSB = 0;
    localparam int SRC_B_LSB = 8;
    localparam int SRC_C_LSB = 16;
    localparam int SRC_W = 4;
    localparam logic [31:0] SEL_MASK = 32'h000f_0f0f;
    localparam logic [31:0] SEL_RESET = 32'h0000_0000;
    // enable and status fields
    localparam int ENABLE_BIT = 0;
    localparam int STATUS_OUT_LSB = 0;
    localparam int STATUS_STATE_LSB = 8;
    // source codes: upper two bits pick the kind of source
    localparam logic [3:0] SRC_DU_CODE = 4'h0;
    localparam logic [1:0] SRC_DEVICE_KIND = 2'h2;
    localparam logic [1:0] SRC_PIN_KIND = 2'h3;
    // bus transfer types and response
    localparam logic HTRANS_ACTIVE_BIT = 1'b1;
    localparam logic HRESP_OKAY = 1'b0;
    // cell function codes
    typedef enum logic [1:0] {
        FUNC_COMB   = 2'b00,
        FUNC_REG    = 2'b01,
        FUNC_STATE  = 2'b10,
        FUNC_TOGGLE = 2'b11
    } lca_func_type;
endpackage : lca_pkg

//--- rtl/lca_cell.sv
module lca_cell (
    input  wire logic                 clock,
    input  wire logic                 cell_reset_n,
    input  wire logic [7:0]           truth_vector,
    input  wire lca_pkg::lca_func_type cell_function_code,
    input  wire logic                 cell_input_a,
    input  wire logic                 cell_input_b,
    input  wire logic                 cell_input_c,
    output logic                      cell_output,
    output logic                      cell_state
);
    import lca_pkg::*;

    logic       state_reg;  // the cell's single flip-flop
    logic       state_next; // its next value
    logic [2:0] table_index; // truth vector index

    // output and next state
    // table lookup and flip-flop use per function code
    always_comb begin
        table_index = {cell_input_c, cell_input_b, cell_input_a};
        state_next = state_reg;
        cell_output = 1'b0;
        case (cell_function_code)
            // plain lookup, flip-flop left as is
            FUNC_COMB: begin
                cell_output = truth_vector[table_index];
            end
            // lookup result registered
            FUNC_REG: begin
                cell_output = state_reg;
                state_next = truth_vector[table_index];
            end
            // state replaces input a in the index
            FUNC_STATE: begin
                table_index = {cell_input_c, cell_input_b, state_reg};
                cell_output = state_reg;
                state_next = truth_vector[table_index];
            end
            // lookup result toggles the state
            FUNC_TOGGLE: begin
                cell_output = state_reg;
                if (truth_vector[table_index]) begin
                    state_next = ~state_reg;
                end
            end
            default: begin
                cell_output = 1'b0;
            end
        endcase
    end

    // flip-flop cleared asynchronously by the block reset
    always_ff @(posedge clock or negedge cell_reset_n) begin
        if (!cell_reset_n) begin
            state_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign cell_state = state_reg;
endmodule : lca_cell

//--- rtl/lca_top.sv
// How it works
// - eight cells, each with two registers
// - cell is truth table plus flip-flop
// - control bits 7:0 hold truth vector
// - control bits 9:8 hold function code
// - output and next state from all four
// - inputs from unit, cells, device, pins
// - first selector: 0 unit, 1-7 cells
// - second selector: 0-7 cell outputs
// - codes 8-11 route device bits by group
// - codes 12-15 route pin bits by group
// - third selector decodes like second
// - disabled block holds cell flip-flops zero
// - one clock, one async reset for cells
module lca_top (
    input  wire logic                            clock,
    input  wire logic                            reset_n,
    input  wire logic                            hsel,
    input  wire logic [31:0]                     haddr,
    input  wire logic [1:0]                      htrans,
    input  wire logic                            hwrite,
    input  wire logic [2:0]                      hsize,
    input  wire logic [31:0]                     hwdata,
    input  wire logic                            hready,
    output logic                                 hreadyout,
    output logic [31:0]                          hrdata,
    output logic                                 hresp,
    input  wire logic                            du_output,
    input  wire logic [lca_pkg::CELL_COUNT-1:0]  device_side_data,
    input  wire logic [lca_pkg::CELL_COUNT-1:0]  pin_side_data,
    output logic [lca_pkg::CELL_COUNT-1:0]       cell_output
);
    import lca_pkg::*;

    // reset release chain
    logic        rst_meta_reg;     // first stage
    logic        reset_sync_n;     // released copy
    // input synchronisers
    logic [7:0]  device_meta_reg;  // first stage, device side
    logic [7:0]  device_sync_reg;  // usable device bits
    logic [7:0]  pin_meta_reg;     // first stage, pin side
    logic [7:0]  pin_sync_reg;     // usable pin bits
    // bus state
    logic        wr_pend_reg;      // write data phase pending
    logic [31:0] wr_addr_reg;      // write address
    logic        rd_pend_reg;      // read waiting one cycle
    logic [31:0] rd_addr_reg;      // read address
    logic [31:0] hrdata_reg;       // read data
    logic [31:0] rd_value;         // decoded read value
    logic        addr_phase;       // transfer accepted
    // registers
    logic [31:0] ctl_reg [CELL_COUNT];  // table_cell_control
    logic [31:0] sel_reg [CELL_COUNT];  // table_input_select
    logic        enable_reg;            // block enable
    // cell wiring
    logic        cell_rst_n_reg;        // block reset of the cells
    logic [7:0]  cell_out_w;            // live cell outputs
    logic [7:0]  cell_state_w;          // cell flip-flops
    logic [7:0]  cell_in_a;             // routed first inputs
    logic [7:0]  cell_in_b;             // routed second inputs
    logic [7:0]  cell_in_c;             // routed third inputs
    logic [7:0]  cell_output_reg;       // registered output copy
    logic [7:0]  truth_w [CELL_COUNT];  // truth vectors
    lca_func_type func_w [CELL_COUNT];  // function codes
    logic [3:0]  src_a_w [CELL_COUNT];  // first selectors
    logic [3:0]  src_b_w [CELL_COUNT];  // second selectors
    logic [3:0]  src_c_w [CELL_COUNT];  // third selectors

    // pick one source bit for a selector code
    function automatic logic route_source(
        input logic [3:0] code,
        input logic       upper,
        input logic       first,
        input logic [7:0] cells,
        input logic [7:0] dev,
        input logic [7:0] pins,
        input logic       unit
    );
        logic result;
        result = cells[code[2:0]];
        // device and pin side codes
        // group bit plus low code bits pick side bit
        if (code[3:2] == SRC_DEVICE_KIND) begin
            result = dev[{upper, code[1:0]}];
        end else if (code[3:2] == SRC_PIN_KIND) begin
            result = pins[{upper, code[1:0]}];
        end else if (first && code == SRC_DU_CODE) begin
            result = unit;
        end
        return result;
    endfunction : route_source

    // reset release through two flip-flops
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            rst_meta_reg <= 1'b0;
            reset_sync_n <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            reset_sync_n <= rst_meta_reg;
        end
    end

    // two-stage synchronisers on device and pin bits
    always_ff @(posedge clock or negedge reset_sync_n) begin
        if (!reset_sync_n) begin
            device_meta_reg <= 8'h00;
            device_sync_reg <= 8'h00;
            pin_meta_reg <= 8'h00;
            pin_sync_reg <= 8'h00;
        end else begin
            device_meta_reg <= device_side_data;
            device_sync_reg <= device_meta_reg;
            pin_meta_reg <= pin_side_data;
            pin_sync_reg <= pin_meta_reg;
        end
    end

    // accepted address phase of an active transfer
    assign addr_phase = hsel && hready && htrans[1] == HTRANS_ACTIVE_BIT;

    // bus phase tracking; reads take one wait state
    always_ff @(posedge clock or negedge reset_sync_n) begin
        if (!reset_sync_n) begin
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= 32'h0000_0000;
            rd_pend_reg <= 1'b0;
            rd_addr_reg <= 32'h0000_0000;
        end else begin
            wr_pend_reg <= addr_phase && hwrite;
            rd_pend_reg <= addr_phase && !hwrite;
            if (addr_phase) begin
                wr_addr_reg <= haddr;
                rd_addr_reg <= haddr;
            end
        end
    end

    // read decode; unmapped or misaligned reads give zero
    always_comb begin
        rd_value = 32'h0000_0000;
        if (rd_addr_reg[31:ADDR_W] == '0 && rd_addr_reg[1:0] == 2'h0) begin
            if (rd_addr_reg[ADDR_W-1:PAGE_LSB] == CTL_PAGE) begin
                rd_value = ctl_reg[rd_addr_reg[INDEX_LSB +: INDEX_W]];
            end else if (rd_addr_reg[ADDR_W-1:PAGE_LSB] == SEL_PAGE) begin
                rd_value = sel_reg[rd_addr_reg[INDEX_LSB +: INDEX_W]];
            end else if (rd_addr_reg[ADDR_W-1:0] == ENABLE_OFFSET) begin
                rd_value[ENABLE_BIT] = enable_reg;
            end else if (rd_addr_reg[ADDR_W-1:0] == STATUS_OFFSET) begin
                rd_value[STATUS_OUT_LSB +: 8] = cell_output_reg;
                rd_value[STATUS_STATE_LSB +: 8] = cell_state_w;
            end
        end
    end

    // read data captured in the wait cycle
    always_ff @(posedge clock or negedge reset_sync_n) begin
        if (!reset_sync_n) begin
            hrdata_reg <= 32'h0000_0000;
        end else if (rd_pend_reg) begin
            hrdata_reg <= rd_value;
        end
    end

    assign hrdata = hrdata_reg;
    assign hreadyout = !rd_pend_reg;
    assign hresp = HRESP_OKAY;

    // register writes
    // per-cell registers, written in the data phase
    always_ff @(posedge clock or negedge reset_sync_n) begin
        if (!reset_sync_n) begin
            for (int i = 0; i < CELL_COUNT; i++) begin
                ctl_reg[i] <= CTL_RESET;
                sel_reg[i] <= SEL_RESET;
            end
        end else if (wr_pend_reg && wr_addr_reg[31:ADDR_W] == '0
                     && wr_addr_reg[1:0] == 2'h0) begin
            // reserved bits masked off and read as zero
            if (wr_addr_reg[ADDR_W-1:PAGE_LSB] == CTL_PAGE) begin
                ctl_reg[wr_addr_reg[INDEX_LSB +: INDEX_W]] <=
                    hwdata & CTL_MASK;
            end else if (wr_addr_reg[ADDR_W-1:PAGE_LSB] == SEL_PAGE) begin
                sel_reg[wr_addr_reg[INDEX_LSB +: INDEX_W]] <=
                    hwdata & SEL_MASK;
            end
        end
    end

    // block enable register
    always_ff @(posedge clock or negedge reset_sync_n) begin
        if (!reset_sync_n) begin
            enable_reg <= 1'b0;
        end else if (wr_pend_reg
                     && wr_addr_reg == {24'h00_0000, ENABLE_OFFSET}) begin
            enable_reg <= hwdata[ENABLE_BIT];
        end
    end

    // disable holds reset
    // cell reset stays active while the block is disabled
    always_ff @(posedge clock or negedge reset_sync_n) begin
        if (!reset_sync_n) begin
            cell_rst_n_reg <= 1'b0;
        end else begin
            cell_rst_n_reg <= enable_reg;
        end
    end

    // one cell per index with its own routing
    for (genvar y = 0; y < CELL_COUNT; y++) begin : g_cell
        localparam logic UPPER = (y >= GROUP_SIZE);
        assign truth_w[y] = ctl_reg[y][TRUTH_LSB +: TRUTH_W];
        assign func_w[y] = lca_func_type'(ctl_reg[y][FUNC_LSB +: FUNC_W]);
        assign src_a_w[y] = sel_reg[y][SRC_A_LSB +: SRC_W];
        assign src_b_w[y] = sel_reg[y][SRC_B_LSB +: SRC_W];
        assign src_c_w[y] = sel_reg[y][SRC_C_LSB +: SRC_W];
        assign cell_in_a[y] = route_source(src_a_w[y], UPPER, 1'b1,
            cell_out_w, device_sync_reg, pin_sync_reg, du_output);
        assign cell_in_b[y] = route_source(src_b_w[y], UPPER, 1'b0,
            cell_out_w, device_sync_reg, pin_sync_reg, du_output);
        assign cell_in_c[y] = route_source(src_c_w[y], UPPER, 1'b0,
            cell_out_w, device_sync_reg, pin_sync_reg, du_output);
        lca_cell u_cell (
            .clock              (clock),
            .cell_reset_n       (cell_rst_n_reg),
            .truth_vector       (truth_w[y]),
            .cell_function_code (func_w[y]),
            .cell_input_a       (cell_in_a[y]),
            .cell_input_b       (cell_in_b[y]),
            .cell_input_c       (cell_in_c[y]),
            .cell_output        (cell_out_w[y]),
            .cell_state         (cell_state_w[y])
        );
    end

    // registered copy of the cell outputs for the port
    always_ff @(posedge clock or negedge reset_sync_n) begin
        if (!reset_sync_n) begin
            cell_output_reg <= 8'h00;
        end else begin
            cell_output_reg <= cell_out_w;
        end
    end

    assign cell_output = cell_output_reg;

    // helper terms for checks
    logic expect0_w; // lookup of cell 0
    logic trig0_w;   // toggle trigger of cell 0
    assign expect0_w = truth_w[0][{cell_in_c[0], cell_in_b[0], cell_in_a[0]}];
    assign trig0_w = expect0_w;

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!reset_sync_n);

    chk_ctl_write: assert property (
        wr_pend_reg && wr_addr_reg[31:ADDR_W] == '0
        && wr_addr_reg[1:0] == 2'h0
        && wr_addr_reg[ADDR_W-1:PAGE_LSB] == CTL_PAGE
        |=> ctl_reg[$past(wr_addr_reg[INDEX_LSB +: INDEX_W])]
            == ($past(hwdata) & CTL_MASK))
        else $error("control register not written");

    chk_disable_clear: assert property (
        !enable_reg |=> cell_state_w == 8'h00)
        else $error("cell state not cleared while disabled");

    chk_comb_table: assert property (
        func_w[0] == FUNC_COMB |->
        cell_out_w[0] == truth_w[0][{cell_in_c[0], cell_in_b[0],
                                     cell_in_a[0]}])
        else $error("lookup output wrong");

    chk_reg_follow: assert property (
        cell_rst_n_reg && func_w[0] == FUNC_REG ##1 cell_rst_n_reg
        |-> cell_state_w[0] == $past(expect0_w)
            && cell_out_w[0] == cell_state_w[0])
        else $error("registered mode state wrong");

    chk_toggle_flip: assert property (
        cell_rst_n_reg && func_w[0] == FUNC_TOGGLE && trig0_w
        ##1 cell_rst_n_reg
        |-> cell_state_w[0] != $past(cell_state_w[0]))
        else $error("toggle did not flip");

    chk_first_unit: assert property (
        src_a_w[0] == SRC_DU_CODE |-> cell_in_a[0] == du_output)
        else $error("first input not data unit");

    chk_second_cell: assert property (
        !src_b_w[6][3] |-> cell_in_b[6] == cell_out_w[src_b_w[6][2:0]])
        else $error("second input cell route wrong");

    chk_device_route: assert property (
        src_b_w[5][3:2] == SRC_DEVICE_KIND |->
        cell_in_b[5] == device_sync_reg[{1'b1, src_b_w[5][1:0]}])
        else $error("device route wrong");

    chk_pin_route: assert property (
        src_a_w[2][3:2] == SRC_PIN_KIND |->
        cell_in_a[2] == pin_sync_reg[{1'b0, src_a_w[2][1:0]}])
        else $error("pin route wrong");

    chk_third_route: assert property (
        src_c_w[7][3:2] == SRC_PIN_KIND |->
        cell_in_c[7] == pin_sync_reg[{1'b1, src_c_w[7][1:0]}])
        else $error("third input route wrong");

    chk_reset_clear: assert property (
        !cell_rst_n_reg |-> cell_state_w == 8'h00)
        else $error("cell state not held in reset");

    // read wait state check
    chk_read_wait: assert property (
        addr_phase && !hwrite |=> !hreadyout ##1 hreadyout)
        else $error("read wait state wrong");

    // main scenarios
    cov_read: cover property (addr_phase && !hwrite ##2 hreadyout);
    cov_toggle: cover property (
        func_w[0] == FUNC_TOGGLE && trig0_w && cell_rst_n_reg);
    cov_reg_mode: cover property (
        func_w[0] == FUNC_REG && cell_rst_n_reg);
    cov_disable: cover property (enable_reg ##1 !enable_reg);
endmodule : lca_top

//--- bench/lca_far_model.sv
// far side: multiplexer outputs and port pins, both asynchronous
module lca_far_model (
    input  wire logic       clock,
    input  wire logic       slow,
    input  wire logic [7:0] dev_level,
    input  wire logic [7:0] pin_level,
    output logic      [7:0] device_side_data,
    output logic      [7:0] pin_side_data
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] dev_q = 8'h00; // late copy for slow mode
    logic [7:0] pin_q = 8'h00; // late copy for slow mode
    // lines move 3 ns after the edge, so the design must synchronise
    initial begin
        device_side_data = 8'h00;
        pin_side_data = 8'h00;
        forever begin
            @(posedge clock);
            #3;
            device_side_data = slow ? dev_q : dev_level;
            pin_side_data = slow ? pin_q : pin_level;
            dev_q = dev_level;
            pin_q = pin_level;
        end
    end
endmodule : lca_far_model

//--- bench/lca_tb_top.sv
// bench: register tasks over the bus, then cell scenarios
module lca_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    import lca_pkg::*;
    logic        clock, reset_n, hsel, hwrite, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic        du_output, slow;
    logic [7:0]  dev_level, pin_level, cell_output, cm;
    logic [7:0]  device_side_data, pin_side_data;
    int          errors, checks;
    lca_top DUT (.clock(clock), .reset_n(reset_n), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hrdata(hrdata), .hresp(hresp), .du_output(du_output),
        .device_side_data(device_side_data),
        .pin_side_data(pin_side_data), .cell_output(cell_output));
    lca_far_model far (.clock(clock), .slow(slow),
        .dev_level(dev_level), .pin_level(pin_level),
        .device_side_data(device_side_data),
        .pin_side_data(pin_side_data));
    // free-running 100 MHz clock
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    // verdict and end of run
    task test_done;
        $display("checks=%0d errors=%0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : test_done
    // compare one word
    task check_word(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check_word
    // bounded wait for hready sampled high
    task wait_ready;
        int   n;
        logic rdy;
        n = 0;
        do begin
            // settled values of the cycle that the next edge ends
            @(negedge clock);
            rdy = hreadyout;
            rd = hrdata;
            @(posedge clock);
            n++;
        end while (rdy !== 1'b1 && n < 20);
        if (rdy !== 1'b1) begin
            errors++;
            test_done;
        end
    endtask : wait_ready
    // one single transfer: address phase, then data phase
    task bus(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge clock);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= a;
        hwrite <= w;
        wait_ready;
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        wait_ready;
    endtask : bus
    task rdchk(input logic [31:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0000_0000);
        check_word(rd, exp);
        check_word(32'(hresp), 32'(HRESP_OKAY));
    endtask : rdchk
    // expected value of a selected cell input
    function automatic logic src_val(int y, int j, logic [3:0] c);
        int g;
        g = (y >= 4) ? 4 : 0;
        if (c[3:2] == SRC_DEVICE_KIND) return dev_level[g + c[1:0]];
        if (c[3:2] == SRC_PIN_KIND) return pin_level[g + c[1:0]];
        if (j == 0 && c == SRC_DU_CODE) return du_output;
        return cm[c[2:0]];
    endfunction : src_val
    // every cell, input and code but the cell's own output; other cells give constants
    task route_pass(input logic [7:0] m, input logic [7:0] dv,
                    input logic [7:0] pn, input logic du);
        logic [31:0] s;
        cm = m;
        dev_level = dv;
        pin_level = pn;
        du_output <= du;
        for (int k = 0; k < 8; k++) bus(1'b1, 32'(4*k), m[k] ? 32'hff : 0);
        for (int y = 0; y < 8; y++) begin
            for (int j = 0; j < 3; j++) begin
                for (int c = 0; c < 16; c++) begin
                    // skip a cell reading its own output
                    if (c < 8 && c == y && !(j == 0 && c == 0)) continue;
                    s = (32'h0008_0808 & ~(32'hf << 8*j)) | (c << 8*j);
                    // truth vector that passes input j straight through
                    bus(1'b1, 32'(4*y),
                        (j == 0) ? 32'haa : (j == 1) ? 32'hcc : 32'hf0);
                    bus(1'b1, 32'(32'h20 + 4*y), s);
                    repeat (6) @(posedge clock);
                    check_word(32'(cell_output[y]),
                               32'(src_val(y, j, c)));
                    bus(1'b1, 32'(4*y), m[y] ? 32'hff : 0);
                end
            end
        end
        $display("test route pass done");
    endtask : route_pass
    initial begin
        reset_n = 1'b0;
        {hsel, hwrite, du_output, slow} = 4'h0;
        {haddr, hwdata} = 64'h0;
        htrans = 2'h0;
        hsize = 3'h2;
        {dev_level, pin_level, cm} = 24'h0;
        errors = 0;
        checks = 0;
        repeat (16) @(posedge clock);
        reset_n <= 1'b1;
        repeat (3) @(posedge clock);
        for (int y = 0; y < 8; y++) begin
            rdchk(32'(4*y), 32'h0);
            rdchk(32'(32'h20 + 4*y), 32'h0);
            bus(1'b1, 32'(4*y), 32'hffff_ffff);
            bus(1'b1, 32'(32'h20 + 4*y), 32'hffff_ffff);
            rdchk(32'(4*y), CTL_MASK);
            rdchk(32'(32'h20 + 4*y), SEL_MASK);
        end
        bus(1'b1, 32'h80, 32'hffff_ffff);
        rdchk(32'h80, 32'h0);
        rdchk(32'h100, 32'h0);
        rdchk(32'h2, 32'h0);
        bus(1'b1, 32'(STATUS_OFFSET), 32'hffff_ffff);
        rdchk(32'(STATUS_OFFSET), 32'h0);
        $display("test registers done");
        // clear the toggle setups so no cell state runs on enable
        for (int k = 0; k < 8; k++) bus(1'b1, 32'(4*k), 32'h0);
        bus(1'b1, 32'(ENABLE_OFFSET), 32'h1);
        route_pass(8'h5a, 8'h33, 8'hc6, 1'b1);
        slow = 1'b1;
        route_pass(8'ha5, 8'hcc, 8'h39, 1'b0);
        dev_level = 8'h00;
        for (int k = 0; k < 8; k++) bus(1'b1, 32'(4*k), 32'h0);
        bus(1'b1, 32'h20, 32'h0008_0800);
        bus(1'b1, 32'h0, 32'h1aa);
        du_output <= 1'b1;
        repeat (4) @(posedge clock);
        rdchk(32'(STATUS_OFFSET), 32'h0101);
        du_output <= 1'b0;
        repeat (4) @(posedge clock);
        rdchk(32'(STATUS_OFFSET), 32'h0);
        bus(1'b1, 32'h0, 32'h3aa);
        @(posedge clock);
        du_output <= 1'b1;
        repeat (3) @(posedge clock);
        du_output <= 1'b0;
        rdchk(32'(STATUS_OFFSET), 32'h0101);
        bus(1'b1, 32'h0, 32'h202);
        repeat (4) @(posedge clock);
        rdchk(32'(STATUS_OFFSET), 32'h0101);
        bus(1'b1, 32'h0, 32'h200);
        repeat (4) @(posedge clock);
        rdchk(32'(STATUS_OFFSET), 32'h0);
        bus(1'b1, 32'h0, 32'h2ff);
        repeat (4) @(posedge clock);
        rdchk(32'(STATUS_OFFSET), 32'h0101);
        $display("test function codes done");
        bus(1'b1, 32'(ENABLE_OFFSET), 32'h0);
        repeat (3) @(posedge clock);
        rdchk(32'(STATUS_OFFSET), 32'h0);
        bus(1'b1, 32'h0, 32'h0ff);
        repeat (3) @(posedge clock);
        rdchk(32'(STATUS_OFFSET), 32'h0001);
        bus(1'b1, 32'(ENABLE_OFFSET), 32'h1);
        repeat (3) @(posedge clock);
        rdchk(32'(STATUS_OFFSET), 32'h0001);
        $display("test disable done");
        test_done;
    end
endmodule : lca_tb_top
